// file: core/ext_status_pkg.sv
// Constants and types shared by the external/status latch block.
// Assumes one 40 MHz clock and a synchronous active-high reset.
package ext_status_pkg;
  // ----------------------------------------------------------------
  // Register map, byte addresses on the AXI4-Lite bus
  // ----------------------------------------------------------------
  localparam int         ADDR_W    = 5;
  localparam logic [4:0] OFF_CMD   = 5'h00;
  localparam logic [4:0] OFF_ICTL  = 5'h04;
  localparam logic [4:0] OFF_RXCTL = 5'h08;
  localparam logic [4:0] OFF_ENA   = 5'h0c;
  localparam logic [4:0] OFF_STAT  = 5'h10;
  localparam logic [4:0] OFF_MODE  = 5'h14;
  localparam logic [4:0] OFF_PEND  = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ZC_POS     = 1;
  localparam int DCD_POS    = 3;
  localparam int SYNC_POS   = 4;
  localparam int CTS_POS    = 5;
  localparam int UND_POS    = 6;
  localparam int BRK_POS    = 7;
  localparam int MASTER_POS = 0;
  localparam int RXEN_POS   = 0;
  localparam int HUNT_POS   = 4;
  localparam int XTAL_POS   = 2;

  // Sources that close on both edges, on rising edge only
  localparam logic [7:0] ANY_MASK  = 8'hb8;
  localparam logic [7:0] RISE_MASK = 8'h42;
  localparam logic [7:0] ZC_MASK   = 8'h02;
  localparam logic [7:0] ENA_MASK  = 8'hfa;
  localparam logic [7:0] ENA_RST   = 8'h00;

  // Command codes in the low three bits of the command register
  localparam logic [2:0] CMD_RST_EXT    = 3'h2;
  localparam logic [2:0] CMD_SEND_ABORT = 3'h3;
  localparam logic [2:0] CMD_RST_UND    = 3'h6;

  localparam logic [2:0] ONES_ABORT  = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_ASYNC, MODE_SYNC, MODE_SDLC, MODE_EXT_SYNC
  } mode_t;

  typedef enum logic [2:0] {
    SEL_CMD, SEL_ICTL, SEL_RXCTL, SEL_ENA, SEL_STAT, SEL_MODE,
    SEL_PEND, SEL_NONE
  } reg_sel_t;
endpackage

// file: core/break_abort_det.sv
// Break (async) and abort (SDLC) detector on the received bit stream.
// Assumes one strobe per received bit, synchronous to sys_clk.
`timescale 1ns/1ps
module break_abort_det
  import ext_status_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  srst,
  input  wire mode_t mode,
  input  wire logic  rx_bit,
  input  wire logic  rx_bit_valid,
  input  wire logic  null_framing,
  output logic       brk_ff,
  output logic       abort_ff
);
  logic [2:0] ones_ff;
  logic       sdlc_set;

  assign sdlc_set = (mode == MODE_SDLC) && rx_bit_valid && rx_bit
                    && (ones_ff >= ONES_ABORT - 3'h1);

  // ----------------------------------------------------------------
  // Run of ones, saturating at seven
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst || mode != MODE_SDLC || (rx_bit_valid && !rx_bit))
      ones_ff <= 3'h0;
    else if (rx_bit_valid && ones_ff != ONES_ABORT)
      ones_ff <= ones_ff + 3'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      brk_ff <= 1'b0;
    else if (mode == MODE_SDLC)
    begin
      if (sdlc_set)
        brk_ff <= 1'b1;
      else if (rx_bit_valid && !rx_bit)
        brk_ff <= 1'b0;
    end
    else if (mode == MODE_ASYNC)
    begin
      // A new break outranks the one bit that would end the old one
      if (null_framing)
        brk_ff <= 1'b1;
      else if (rx_bit_valid && rx_bit)
        brk_ff <= 1'b0;
    end
    else
      brk_ff <= 1'b0;
  end

  // One pulse per abort, used to throw the receiver into hunt
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      abort_ff <= 1'b0;
    else
      abort_ff <= sdlc_set && !brk_ff;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sync_no_break_a: assert property (
    (mode == MODE_SYNC || mode == MODE_EXT_SYNC) |=> !brk_ff)
    else $error("break set in byte sync mode");
  sdlc_zero_clr_a: assert property (
    mode == MODE_SDLC && rx_bit_valid && !rx_bit |=> !brk_ff)
    else $error("abort not cleared by a zero");
  abort_break_a: assert property (
    abort_ff |-> brk_ff && $past(ones_ff) >= 3'h6)
    else $error("abort pulse without seven ones");
endmodule

// file: core/ext_status_interrupt_latch.sv
// External/status latch and pending logic of one serial channel.
// Assumes AXI4-Lite register access and pins synchronous to sys_clk.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Contract
// - Enabled sources other than zero count pass through the shared latch to status.
// - Disabled sources read live and never close the latches.
// - Master enable bit 0 gates pending; latches still work.
// - An enabled change closes all latches at once; underrun and zero count on rise only.
// - Reset-status command reopens the latches.
// - Pending is set while the latches are closed.
// - Five sources share identical enable behaviour.
// - Break reads 0 in byte sync; async null-break until a one.
// - SDLC abort is seven ones, cleared by a zero, forces hunt.
// - Both break edges close the latches when break is enabled.
// - Underrun clear by command does not close the latches.
// - Underrun sets on CRC load or send abort; always in async.
// - CTS and DCD follow pins and close on either edge.
// - Odd pin toggles while closed re-close the latches right after reopen.
// - Zero count follows counter, closes on set, reads live.
// - Zero count reads zero while its enable is clear.
// - Async and external sync: sync bit follows sync pin.
// - Crystal on in those modes forces sync bit to zero.
// - Byte sync: hunt set by command, cleared on sync found.
// - SDLC hunt by command, abort or enable; flag leaves it.
module ext_status_interrupt_latch
  import ext_status_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              cts_pin,
  input  wire logic              dcd_pin,
  input  wire logic              sync_pin,
  input  wire logic              rx_bit,
  input  wire logic              rx_bit_valid,
  input  wire logic              rx_null_framing,
  input  wire logic              flag_found,
  input  wire logic              char_sync_found,
  input  wire logic              crc_loaded,
  input  wire logic              baud_zero,
  output logic                   interrupt_pending
);
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]        wdata_ff;
  logic              wstrb0_ff;
  logic              aw_held_ff;
  logic              w_held_ff;
  logic              wr_fire;
  logic              wr_ok;
  reg_sel_t          wr_sel;
  logic              master_ff;
  logic              rx_en_ff;
  logic [7:0]        en_ff;
  mode_t             mode_ff;
  logic              xtal_ff;
  logic              und_ff;
  logic              hunt_ff;
  logic              brk_live;
  logic              abort_pulse;
  logic [7:0]        live_v;
  logic [7:0]        lat_ff;
  logic [7:0]        ev_v;
  logic [7:0]        status_v;
  logic              closed_ff;
  logic              close_ev;
  logic              nxt_closed;
  logic              nxt_master;
  logic              sync_forced;
  logic              pin_sync_mode;
  logic              cmd_rst_ext;
  logic              cmd_send_abort;
  logic              cmd_rst_und;
  logic              cmd_hunt;
  logic              rx_en_rise;

  // ----------------------------------------------------------------
  // Address decode, shared by the write and read paths
  // ----------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFF_CMD:   decode = SEL_CMD;
      OFF_ICTL:  decode = SEL_ICTL;
      OFF_RXCTL: decode = SEL_RXCTL;
      OFF_ENA:   decode = SEL_ENA;
      OFF_STAT:  decode = SEL_STAT;
      OFF_MODE:  decode = SEL_MODE;
      OFF_PEND:  decode = SEL_PEND;
      default:   decode = SEL_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_sel  = decode(awaddr_ff);
  assign wr_ok   = wr_fire && wstrb0_ff;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      aw_held_ff    <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_ff     <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_ff    <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_ff     <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_ff    <= 1'b0;
    else if (!aw_held_ff && !s_axi_bvalid)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      w_held_ff    <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_ff     <= '0;
      wstrb0_ff    <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_ff    <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_ff     <= s_axi_wdata[7:0];
      wstrb0_ff    <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_held_ff    <= 1'b0;
    else if (!w_held_ff && !s_axi_bvalid)
      s_axi_wready <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Commands and control registers
  // ----------------------------------------------------------------
  assign cmd_rst_ext    = wr_ok && wr_sel == SEL_CMD
                          && wdata_ff[2:0] == CMD_RST_EXT;
  assign cmd_send_abort = wr_ok && wr_sel == SEL_CMD
                          && wdata_ff[2:0] == CMD_SEND_ABORT;
  assign cmd_rst_und    = wr_ok && wr_sel == SEL_CMD
                          && wdata_ff[2:0] == CMD_RST_UND;
  assign cmd_hunt       = wr_ok && wr_sel == SEL_RXCTL
                          && wdata_ff[HUNT_POS];
  assign rx_en_rise     = wr_ok && wr_sel == SEL_RXCTL
                          && wdata_ff[RXEN_POS] && !rx_en_ff;
  assign nxt_master     = (wr_ok && wr_sel == SEL_ICTL) ?
                          wdata_ff[MASTER_POS] : master_ff;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      master_ff <= 1'b0;
      rx_en_ff  <= 1'b0;
      en_ff     <= ENA_RST;
      mode_ff   <= MODE_ASYNC;
      xtal_ff   <= 1'b0;
    end
    else
    begin
      master_ff <= nxt_master;
      if (wr_ok && wr_sel == SEL_RXCTL)
        rx_en_ff <= wdata_ff[RXEN_POS];
      if (wr_ok && wr_sel == SEL_ENA)
        en_ff    <= wdata_ff & ENA_MASK;
      if (wr_ok && wr_sel == SEL_MODE)
      begin
        mode_ff  <= mode_t'(wdata_ff[1:0]);
        xtal_ff  <= wdata_ff[XTAL_POS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal sources: underrun, hunt, break/abort
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      und_ff <= 1'b0;
    else if (crc_loaded || cmd_send_abort)
      und_ff <= 1'b1;
    else if (cmd_rst_und)
      und_ff <= 1'b0;
  end

  // Entry outranks exit so an abort on the flag cycle is not lost
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      hunt_ff <= 1'b0;
    else if (mode_ff == MODE_SYNC)
    begin
      if (cmd_hunt)
        hunt_ff <= 1'b1;
      else if (char_sync_found)
        hunt_ff <= 1'b0;
    end
    else if (mode_ff == MODE_SDLC)
    begin
      if (cmd_hunt || abort_pulse || rx_en_rise)
        hunt_ff <= 1'b1;
      else if (flag_found)
        hunt_ff <= 1'b0;
    end
    else
      hunt_ff <= 1'b0;
  end

  break_abort_det u_brk (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .mode         (mode_ff),
    .rx_bit       (rx_bit),
    .rx_bit_valid (rx_bit_valid),
    .null_framing (rx_null_framing),
    .brk_ff       (brk_live),
    .abort_ff     (abort_pulse)
  );

  // ----------------------------------------------------------------
  // Live source vector and the shared latch
  // ----------------------------------------------------------------
  assign pin_sync_mode = mode_ff == MODE_ASYNC
                         || mode_ff == MODE_EXT_SYNC;
  assign sync_forced   = pin_sync_mode && xtal_ff;

  always_comb
  begin
    live_v           = '0;
    live_v[BRK_POS]  = brk_live;
    live_v[UND_POS]  = (mode_ff == MODE_ASYNC) || und_ff;
    live_v[CTS_POS]  = cts_pin;
    live_v[DCD_POS]  = dcd_pin;
    live_v[SYNC_POS] = pin_sync_mode ? (sync_pin && !xtal_ff)
                                     : hunt_ff;
    live_v[ZC_POS]   = baud_zero && en_ff[ZC_POS];
  end

  // The latch value doubles as the reference for edge detection:
  // after a reopen, an odd toggle count still differs from it.
  always_comb
  begin
    ev_v = en_ff & (((live_v ^ lat_ff) & ANY_MASK)
                    | (live_v & ~lat_ff & RISE_MASK));
    if (sync_forced)
      ev_v[SYNC_POS] = 1'b0;
  end

  assign close_ev   = !closed_ff && (|ev_v);
  assign nxt_closed = close_ev
                      || (closed_ff && !cmd_rst_ext);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      lat_ff <= '0;
    else if (!closed_ff)
      lat_ff <= live_v;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      closed_ff <= 1'b0;
    else
      closed_ff <= nxt_closed;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      interrupt_pending <= 1'b0;
    else
      interrupt_pending <= nxt_closed && nxt_master;
  end

  // Enabled bits read the latch, others and zero count read live
  assign status_v = (en_ff & lat_ff & ~ZC_MASK)
                    | (~en_ff & live_v)
                    | (live_v & ZC_MASK);

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
      unique case (decode(s_axi_araddr))
        SEL_CMD:   s_axi_rdata      <= '0;
        SEL_ICTL:  s_axi_rdata[0]   <= master_ff;
        SEL_RXCTL: s_axi_rdata[0]   <= rx_en_ff;
        SEL_ENA:   s_axi_rdata[7:0] <= en_ff;
        SEL_STAT:  s_axi_rdata[7:0] <= status_v;
        SEL_MODE:  s_axi_rdata[2:0] <= {xtal_ff, mode_ff};
        SEL_PEND:  s_axi_rdata[0]   <= interrupt_pending;
        SEL_NONE:  s_axi_rresp      <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid  <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  pend_cause_a: assert property (
    ##1 interrupt_pending == (closed_ff && master_ff))
    else $error("pending does not track closed latches");
  pend_master_a: assert property (
    !master_ff |-> !interrupt_pending)
    else $error("pending set without master enable");
  close_ev_a: assert property (
    !closed_ff && (|ev_v) |=> closed_ff ##0 lat_ff == $past(live_v))
    else $error("latches failed to close on change");
  stay_open_a: assert property (
    !closed_ff && ((live_v ^ lat_ff) & en_ff) == 8'h00 |=> !closed_ff)
    else $error("latches closed with no enabled change");
  hold_latch_a: assert property (
    closed_ff && !cmd_rst_ext |=> closed_ff && $stable(lat_ff))
    else $error("closed latch value changed");
  reopen_a: assert property (
    closed_ff && cmd_rst_ext |=> !closed_ff ##1 lat_ff == $past(live_v))
    else $error("reset command did not reopen latches");
  live_unlatched_a: assert property (
    !en_ff[CTS_POS] |-> status_v[CTS_POS] == cts_pin)
    else $error("disabled source not read live");
  zc_live_a: assert property (
    status_v[ZC_POS] == (baud_zero && en_ff[ZC_POS]))
    else $error("zero count not live or not forced");
  und_async_a: assert property (
    mode_ff == MODE_ASYNC |-> status_v[UND_POS] || en_ff[UND_POS])
    else $error("underrun clear in async mode");
  abort_hunt_a: assert property (
    mode_ff == MODE_SDLC && abort_pulse && $stable(mode_ff) |=> hunt_ff)
    else $error("abort did not force hunt");
  xtal_sync_a: assert property (
    sync_forced |-> !live_v[SYNC_POS] && !ev_v[SYNC_POS])
    else $error("sync bit not forced with crystal");

  close_cov: cover property (!closed_ff ##1 closed_ff && master_ff);
  reopen_cov: cover property (closed_ff && cmd_rst_ext ##1 !closed_ff);
  brk_cov: cover property (closed_ff && $changed(brk_live));
  hunt_cov: cover property ($rose(hunt_ff) ##[1:20] $fell(hunt_ff));
endmodule

// file: tb/axi_host.sv
// Host processor model: AXI4-Lite master plus the status-copy routine.
// Assumes a slave that answers each channel with its own ready.
`timescale 1ns/1ps
module axi_host
  import ext_status_pkg::*;
(
  input  wire logic              sys_clk,
  output logic [ADDR_W-1:0]      s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [31:0]            s_axi_wdata,
  output logic [3:0]             s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [31:0]       s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  logic [7:0] copy_ff;
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    copy_ff = 8'h00;
  end
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge sys_clk);
      if (!ad && s_axi_awready)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready)
      begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && dd));
    while (!s_axi_bvalid)
      @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Service: keep a copy, zero count held 0, then reopen the latches
  task automatic service();
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFF_STAT, d, r);
    copy_ff = d[7:0] & ~ZC_MASK;
    wr(OFF_CMD, {29'h0, CMD_RST_EXT});
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the external/status latch block.
// Assumes the host model drives the register bus; pins driven here.
`timescale 1ns/1ps
module tb;
  import ext_status_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic cts_pin = 1'b0, dcd_pin = 1'b0, sync_pin = 1'b0;
  logic baud_zero = 1'b0, char_sync_found = 1'b0, zero_in = 1'b0;
  logic rx_bit = 1'b0, rx_vld = 1'b0, crc_ld = 1'b0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, interrupt_pending;
  int error_cnt = 0;
  int checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  ext_status_interrupt_latch ext_status_interrupt_latch_i (
    .sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cts_pin(cts_pin), .dcd_pin(dcd_pin),
    .sync_pin(sync_pin), .rx_bit(rx_bit), .rx_bit_valid(rx_vld),
    .rx_null_framing(zero_in), .flag_found(zero_in),
    .char_sync_found(char_sync_found), .crc_loaded(crc_ld),
    .baud_zero(baud_zero), .interrupt_pending(interrupt_pending));
  axi_host axi_host_i (
    .sys_clk(sys_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_host_i.rd(a, d, r);
    check(d & {24'h0, m}, {24'h0, e});
  endtask
  task automatic pend(input logic e);
    repeat (3) @(posedge sys_clk);
    check({31'h0, interrupt_pending}, {31'h0, e});
  endtask
  task automatic cmd(input logic [2:0] c);
    axi_host_i.wr(OFF_CMD, {29'h0, c});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rchk(OFF_ENA, 8'hff, ENA_RST);
    rchk(OFF_PEND, 8'hff, 8'h00);
    axi_host_i.rd(5'h1c, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
    axi_host_i.wr(5'h1c, 32'h0);
    check({30'h0, bresp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
  endtask
  task automatic t_live();
    axi_host_i.wr(OFF_ICTL, 32'h1);
    {cts_pin, sync_pin} <= 2'h3;
    pend(1'b0);
    rchk(OFF_STAT, 8'h30, 8'h30);
    {cts_pin, sync_pin} <= 2'h0;
    pend(1'b0);
    rchk(OFF_STAT, 8'h30, 8'h00);
    $display("test live done");
  endtask
  task automatic t_latch();
    axi_host_i.wr(OFF_ENA, 32'h20);
    cmd(CMD_RST_EXT);
    pend(1'b0);
    cts_pin <= 1'b1;
    pend(1'b1);
    cts_pin <= 1'b0;
    pend(1'b1);
    rchk(OFF_STAT, 8'h20, 8'h20);
    axi_host_i.service();
    pend(1'b1);
    cts_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cts_pin <= 1'b0;
    axi_host_i.service();
    pend(1'b0);
    $display("test latch done");
  endtask
  task automatic t_master();
    axi_host_i.wr(OFF_ICTL, 32'h0);
    axi_host_i.wr(OFF_ENA, 32'h08);
    dcd_pin <= 1'b1;
    pend(1'b0);
    dcd_pin <= 1'b0;
    pend(1'b0);
    rchk(OFF_STAT, 8'h08, 8'h08);
    axi_host_i.wr(OFF_ICTL, 32'h1);
    pend(1'b1);
    $display("test master done");
  endtask
  task automatic t_zero();
    axi_host_i.wr(OFF_ENA, 32'h00);
    cmd(CMD_RST_EXT);
    baud_zero <= 1'b1;
    pend(1'b0);
    rchk(OFF_STAT, ZC_MASK, 8'h00);
    baud_zero <= 1'b0;
    axi_host_i.wr(OFF_ENA, {24'h0, ZC_MASK});
    cmd(CMD_RST_EXT);
    pend(1'b0);
    baud_zero <= 1'b1;
    pend(1'b1);
    baud_zero <= 1'b0;
    rchk(OFF_STAT, ZC_MASK, 8'h00);
    cmd(CMD_RST_EXT);
    pend(1'b0);
    $display("test zero count done");
  endtask
  task automatic t_under();
    axi_host_i.wr(OFF_MODE, 32'h1);
    axi_host_i.wr(OFF_ENA, 32'h40);
    cmd(CMD_RST_EXT);
    pend(1'b0);
    cmd(CMD_SEND_ABORT);
    pend(1'b1);
    rchk(OFF_STAT, 8'h40, 8'h40);
    cmd(CMD_RST_EXT);
    cmd(CMD_RST_UND);
    pend(1'b0);
    rchk(OFF_STAT, 8'h40, 8'h00);
    crc_ld <= 1'b1;
    @(posedge sys_clk);
    crc_ld <= 1'b0;
    pend(1'b1);
    cmd(CMD_RST_EXT);
    $display("test underrun done");
  endtask
  task automatic t_hunt();
    axi_host_i.wr(OFF_ENA, 32'h10);
    cmd(CMD_RST_EXT);
    pend(1'b0);
    axi_host_i.wr(OFF_RXCTL, 32'h10);
    pend(1'b1);
    rchk(OFF_STAT, 8'h10, 8'h10);
    char_sync_found <= 1'b1;
    @(posedge sys_clk);
    char_sync_found <= 1'b0;
    cmd(CMD_RST_EXT);
    pend(1'b1);
    rchk(OFF_STAT, 8'h10, 8'h00);
    $display("test hunt done");
  endtask
  // Enabled abort, hunt left live: abort sets hunt, zero clears abort
  task automatic t_abort();
    axi_host_i.wr(OFF_MODE, 32'h2);
    axi_host_i.wr(OFF_ENA, 32'h80);
    cmd(CMD_RST_EXT);
    pend(1'b0);
    {rx_bit, rx_vld} <= 2'h3;
    repeat (7) @(posedge sys_clk);
    rx_vld <= 1'b0;
    pend(1'b1);
    rchk(OFF_STAT, 8'h90, 8'h90);
    {rx_bit, rx_vld} <= 2'h1;
    @(posedge sys_clk);
    rx_vld <= 1'b0;
    cmd(CMD_RST_EXT);
    pend(1'b1);
    rchk(OFF_STAT, 8'h90, 8'h10);
    $display("test abort done");
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_live();
    t_latch();
    t_master();
    t_zero();
    t_under();
    t_hunt();
    t_abort();
    give_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end
endmodule
